/* File: shared/display_dram_consts.vh */
`ifndef DISPLAY_DRAM_CONSTS_VH
`define DISPLAY_DRAM_CONSTS_VH

// Register byte addresses on the Avalon-MM slave.
`define REG_CTRL          4'h0
`define REG_STATUS        4'h4
`define REG_STRAP         4'h8

// Control register fields and reset values.
`define CTRL_SEQ_RESET    0
`define CTRL_DECODE_EN    1
`define CTRL_WIN_LSB      2
`define CTRL_WIN_MSB      4
`define CTRL_PAGE_LSB     5
`define CTRL_PAGE_MSB     6
`define SEQ_RESET_INIT    1'h1
`define DECODE_EN_INIT    1'h1
`define WINDOW_INIT       3'h5
`define PAGE_INIT         2'h0

// Status register fields.
`define STAT_STATE_MSB    5
`define STAT_OWNER_LSB    6
`define STAT_OWNER_MSB    7
`define STAT_HOST_PEND    8
`define STAT_STRAP_VALID  9

// Strap register fields.
`define STRAP_CFG_MSB     7
`define STRAP_OPT_LSB     8
`define STRAP_OPT_MSB     14
`define OPT_ALT_STROBE    6

// Sequencer states, one-hot.
`define ST_IDLE           6'h01
`define ST_ROW            6'h02
`define ST_RAS            6'h04
`define ST_COL            6'h08
`define ST_CAS            6'h10
`define ST_PRE            6'h20

// Access owners.
`define OWN_HOST          2'h0
`define OWN_DISPLAY       2'h1
`define OWN_REFRESH       2'h2

// Phase lengths as last count value, in clock cycles.
`define RAS_HOLD          3'h1
`define CAS_HOLD          3'h2
`define PRE_HOLD          3'h1
`define STRAP_DELAY       2'h2

// Pin synchroniser width.
`define PIN_SYNC_W        56

`endif

/* File: logic/sync_2ff.v */
`timescale 1ns/10ps
module sync_2ff #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input  wire             clk,
   input  wire             reset_n,
   // Asynchronous inputs and their synchronised copies
   input  wire [WIDTH-1:0] asyncIn,
   output reg  [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1_q;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1_q <= {WIDTH{1'b0}};
         syncOut  <= {WIDTH{1'b0}};
      end else begin
         stage1_q <= asyncIn;
         syncOut  <= stage1_q;
      end
   end

endmodule // sync_2ff

/* File: logic/display_dram_interface.v */
// Behaviour
// - Display and refresh addresses become DRAM row/column addresses, shared with host.
// - Refresh, display and host accesses are arbitrated; one owns the DRAM at once.
// - Sequencer drives all DRAM strobe timing and cycle start/owner sync outputs.
// - Host memory cycles in the display window become requests to the sequencer.
// - Row then column address is driven on the 10-bit multiplexed address bus.
// - 16-bit data bus is driven for writes and sampled for reads.
// - Data bus drivers are off during reset; the DRAM data bus driver is also off while the sequencer is held reset.
// - Data bits 3:0 and 12:9 are captured after reset into a read-only register.
// - Data bits 8:4 and 14:13 captured after reset select hardware options.
// - One active-low row strobe serves the single 256Kx16 DRAM.
// - Default mode: low and high byte column strobes plus one write enable.
`timescale 1ns/10ps
`include "display_dram_consts.vh"
module display_dram_interface (
   // Clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // Avalon-MM register slave
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   // Host memory bus pins
   input  wire [19:0] hostAddr,
   input  wire        hostMemRead_n,
   input  wire        hostMemWrite_n,
   input  wire        hostByteHigh_n,
   input  wire        hostMemEnable,
   input  wire [15:0] hostDataIn,
   output reg  [15:0] hostDataOut,
   output reg         hostDataOe,
   output reg         hostReady,
   // Display timing controller
   input  wire        displayReq,
   input  wire [17:0] displayAddr,
   input  wire        refreshReq,
   input  wire [8:0]  refreshRow,
   output reg         displayAck,
   output reg  [15:0] displayData,
   output reg         refreshAck,
   output reg         cycleStart,
   output reg  [1:0]  cycleOwner,
   // Display DRAM pins
   output reg  [9:0]  dramMuxAddr,
   input  wire [15:0] dramDataBusIn,
   output reg  [15:0] dramDataBusOut,
   output reg         dramDataBusOe,
   output reg         rowStrobe_n,
   output reg         lowByteColStrobe_n,
   output reg         highByteColStrobe_n,
   output reg         writeStrobe_n
);

   // Register file state.
   reg        seqReset_q;
   reg        decodeEn_q;
   reg [2:0]  windowSel_q;
   reg [1:0]  hostPage_q;
   reg [7:0]  strapCfg_q;
   reg [6:0]  strapOpt_q;
   reg        strapValid_q;
   reg [1:0]  strapCnt_q;

   // Host request state.
   reg        hostStrobePrev_q;
   reg        hostPend_q;
   reg        hostWe_q;
   reg [17:0] hostWord_q;
   reg        hostLowEn_q;
   reg        hostHighEn_q;
   reg [15:0] hostWdata_q;
   reg        hostDone_q;
   reg [15:0] hostRdata_q;

   // Sequencer state.
   reg [5:0]  state_q;
   reg [2:0]  cnt_q;
   reg [8:0]  colAddr_q;
   reg        cycWe_q;
   reg        cycLowEn_q;
   reg        cycHighEn_q;
   reg [15:0] cycWdata_q;

   wire [`PIN_SYNC_W-1:0] pinSync;
   wire        memEnS;
   wire        hostRdS;
   wire        hostWrS;
   wire        hostBheS;
   wire [19:0] hostAddrS;
   wire [15:0] hostDataS;
   wire [15:0] dramDataS;
   wire        hostStrobe;
   wire        hostHit;
   wire        hostStart;
   wire        altStrobe;
   wire [31:0] statusWord;
   wire [31:0] strapWord;
   wire [31:0] ctrlWord;

   // All pins from outside pass two flops; strobes are inverted so reset means idle.
   sync_2ff #(
      .WIDTH(`PIN_SYNC_W)
   ) pinSyncInst (
      .clk    (clk),
      .reset_n(reset_n),
      .asyncIn({hostMemEnable, ~hostMemRead_n, ~hostMemWrite_n, ~hostByteHigh_n,
                hostAddr, hostDataIn, dramDataBusIn}),
      .syncOut(pinSync)
   );

   assign memEnS    = pinSync[55];
   assign hostRdS   = pinSync[54];
   assign hostWrS   = pinSync[53];
   assign hostBheS  = pinSync[52];
   assign hostAddrS = pinSync[51:32];
   assign hostDataS = pinSync[31:16];
   assign dramDataS = pinSync[15:0];

   assign hostStrobe = hostRdS | hostWrS;
   assign hostHit    = memEnS & decodeEn_q & ~seqReset_q &
                       (hostAddrS[19:17] == windowSel_q);
   assign hostStart  = hostStrobe & ~hostStrobePrev_q & hostHit & ~hostPend_q &
                       ~hostDataOe;
   assign altStrobe  = strapOpt_q[`OPT_ALT_STROBE];

   assign ctrlWord   = {25'h0, hostPage_q, windowSel_q, decodeEn_q, seqReset_q};
   assign statusWord = {22'h0, strapValid_q, hostPend_q, cycleOwner, state_q};
   assign strapWord  = {17'h0, strapOpt_q, strapCfg_q};

   // Avalon-MM slave: answers one cycle after a request is seen; a write lands as the wait ends.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'h1;
         avs_readdata    <= 32'h0;
         seqReset_q      <= `SEQ_RESET_INIT;
         decodeEn_q      <= `DECODE_EN_INIT;
         windowSel_q     <= `WINDOW_INIT;
         hostPage_q      <= `PAGE_INIT;
      end else begin
         avs_waitrequest <= 1'h1;
         if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_waitrequest <= 1'h0;
            if (avs_read) begin
               case (avs_address)
                  `REG_CTRL:   avs_readdata <= ctrlWord;
                  `REG_STATUS: avs_readdata <= statusWord;
                  `REG_STRAP:  avs_readdata <= strapWord;
                  default:     avs_readdata <= 32'h0;
               endcase
            end
         end
         if (avs_write & !avs_waitrequest & (avs_address == `REG_CTRL) & avs_byteenable[0]) begin
            seqReset_q  <= avs_writedata[`CTRL_SEQ_RESET];
            decodeEn_q  <= avs_writedata[`CTRL_DECODE_EN];
            windowSel_q <= avs_writedata[`CTRL_WIN_MSB:`CTRL_WIN_LSB];
            hostPage_q  <= avs_writedata[`CTRL_PAGE_MSB:`CTRL_PAGE_LSB];
         end
      end
   end

   // Straps are taken from the synchronised data bus once it has settled after reset.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         strapCnt_q   <= 2'h0;
         strapValid_q <= 1'h0;
         strapCfg_q   <= 8'h0;
         strapOpt_q   <= 7'h0;
      end else if (!strapValid_q) begin
         if (strapCnt_q == `STRAP_DELAY) begin
            strapValid_q <= 1'h1;
            strapCfg_q   <= {dramDataS[12:9], dramDataS[3:0]};
            strapOpt_q   <= {dramDataS[14:13], dramDataS[8:4]};
         end else begin
            strapCnt_q <= strapCnt_q + 2'h1;
         end
      end
   end

   // Host cycle decode, wait signalling and read data return.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hostStrobePrev_q <= 1'h0;
         hostPend_q       <= 1'h0;
         hostWe_q         <= 1'h0;
         hostWord_q       <= 18'h0;
         hostLowEn_q      <= 1'h0;
         hostHighEn_q     <= 1'h0;
         hostWdata_q      <= 16'h0;
         hostReady        <= 1'h1;
         hostDataOe       <= 1'h0;
         hostDataOut      <= 16'h0;
      end else begin
         hostStrobePrev_q <= hostStrobe;
         if (seqReset_q) begin
            hostPend_q <= 1'h0;
            hostReady  <= 1'h1;
         end else if (hostStart) begin
            hostPend_q   <= 1'h1;
            hostReady    <= 1'h0;
            hostWe_q     <= hostWrS;
            hostWord_q   <= {hostPage_q, hostAddrS[16:1]};
            hostLowEn_q  <= ~hostAddrS[0] | hostRdS;
            hostHighEn_q <= hostBheS | hostRdS;
            hostWdata_q  <= hostDataS;
         end else if (hostDone_q) begin
            hostPend_q <= 1'h0;
            hostReady  <= 1'h1;
            if (!hostWe_q) begin
               hostDataOut <= hostRdata_q;
               hostDataOe  <= 1'h1;
            end
         end
         if (!hostStrobe) begin
            hostDataOe <= 1'h0;
         end
      end
   end

   // DRAM sequencer: arbitration, address multiplexing and strobe timing.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q             <= `ST_IDLE;
         cnt_q               <= 3'h0;
         colAddr_q           <= 9'h0;
         cycWe_q             <= 1'h0;
         cycLowEn_q          <= 1'h0;
         cycHighEn_q         <= 1'h0;
         cycWdata_q          <= 16'h0;
         cycleOwner          <= `OWN_HOST;
         cycleStart          <= 1'h0;
         displayAck          <= 1'h0;
         displayData         <= 16'h0;
         refreshAck          <= 1'h0;
         hostDone_q          <= 1'h0;
         hostRdata_q         <= 16'h0;
         dramMuxAddr         <= 10'h0;
         dramDataBusOut      <= 16'h0;
         dramDataBusOe       <= 1'h0;
         rowStrobe_n         <= 1'h1;
         lowByteColStrobe_n  <= 1'h1;
         highByteColStrobe_n <= 1'h1;
         writeStrobe_n       <= 1'h1;
      end else begin
         cycleStart <= 1'h0;
         displayAck <= 1'h0;
         refreshAck <= 1'h0;
         hostDone_q <= 1'h0;
         if (seqReset_q) begin
            state_q             <= `ST_IDLE;
            dramDataBusOe       <= 1'h0;
            rowStrobe_n         <= 1'h1;
            lowByteColStrobe_n  <= 1'h1;
            highByteColStrobe_n <= 1'h1;
            writeStrobe_n       <= 1'h1;
         end else begin
            case (state_q)
               `ST_IDLE: begin
                  if (refreshReq) begin
                     cycleOwner  <= `OWN_REFRESH;
                     dramMuxAddr <= {1'b0, refreshRow};
                     cycWe_q     <= 1'h0;
                     state_q     <= `ST_ROW;
                     cycleStart  <= 1'h1;
                  end else if (displayReq) begin
                     cycleOwner  <= `OWN_DISPLAY;
                     dramMuxAddr <= {1'b0, displayAddr[17:9]};
                     colAddr_q   <= displayAddr[8:0];
                     cycWe_q     <= 1'h0;
                     cycLowEn_q  <= 1'h1;
                     cycHighEn_q <= 1'h1;
                     state_q     <= `ST_ROW;
                     cycleStart  <= 1'h1;
                  end else if (hostPend_q & !hostDone_q) begin
                     cycleOwner  <= `OWN_HOST;
                     dramMuxAddr <= {1'b0, hostWord_q[17:9]};
                     colAddr_q   <= hostWord_q[8:0];
                     cycWe_q     <= hostWe_q;
                     cycLowEn_q  <= hostLowEn_q;
                     cycHighEn_q <= hostHighEn_q;
                     cycWdata_q  <= hostWdata_q;
                     state_q     <= `ST_ROW;
                     cycleStart  <= 1'h1;
                  end
               end
               `ST_ROW: begin
                  rowStrobe_n <= 1'h0;
                  cnt_q       <= 3'h0;
                  state_q     <= `ST_RAS;
               end
               `ST_RAS: begin
                  if (cnt_q == `RAS_HOLD) begin
                     cnt_q <= 3'h0;
                     if (cycleOwner == `OWN_REFRESH) begin
                        // Acked as the row strobe rises, so the request drops before idle.
                        rowStrobe_n <= 1'h1;
                        refreshAck  <= 1'h1;
                        state_q     <= `ST_PRE;
                     end else begin
                        dramMuxAddr <= {1'b0, colAddr_q};
                        if (cycWe_q) begin
                           dramDataBusOut <= cycWdata_q;
                           dramDataBusOe  <= 1'h1;
                        end
                        state_q <= `ST_COL;
                     end
                  end else begin
                     cnt_q <= cnt_q + 3'h1;
                  end
               end
               `ST_COL: begin
                  if (altStrobe) begin
                     highByteColStrobe_n <= 1'h0;
                     lowByteColStrobe_n  <= ~(cycWe_q & cycLowEn_q);
                     writeStrobe_n       <= ~(cycWe_q & cycHighEn_q);
                  end else begin
                     lowByteColStrobe_n  <= ~cycLowEn_q;
                     highByteColStrobe_n <= ~cycHighEn_q;
                     writeStrobe_n       <= ~cycWe_q;
                  end
                  cnt_q   <= 3'h0;
                  state_q <= `ST_CAS;
               end
               `ST_CAS: begin
                  if (cnt_q == `CAS_HOLD) begin
                     rowStrobe_n         <= 1'h1;
                     lowByteColStrobe_n  <= 1'h1;
                     highByteColStrobe_n <= 1'h1;
                     writeStrobe_n       <= 1'h1;
                     dramDataBusOe       <= 1'h0;
                     cnt_q               <= 3'h0;
                     state_q             <= `ST_PRE;
                     if (cycleOwner == `OWN_DISPLAY) begin
                        displayData <= dramDataS;
                        displayAck  <= 1'h1;
                     end else begin
                        hostRdata_q <= dramDataS;
                        hostDone_q  <= 1'h1;
                     end
                  end else begin
                     cnt_q <= cnt_q + 3'h1;
                  end
               end
               `ST_PRE: begin
                  if (cnt_q == `PRE_HOLD) begin
                     state_q <= `ST_IDLE;
                  end else begin
                     cnt_q <= cnt_q + 3'h1;
                  end
               end
               default: begin
                  state_q <= `ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule // display_dram_interface

/* File: verification/display_dram_interface_assertions.sv */
`timescale 1ns/10ps
`include "display_dram_consts.vh"
module display_dram_interface_assertions (
   // Clock and reset
   input wire logic       clk,
   input wire logic       reset_n,
   // Watched ports
   input wire logic       avs_read,
   input wire logic       avs_write,
   input wire logic       avs_waitrequest,
   input wire logic       hostReady,
   input wire logic       displayAck,
   input wire logic       cycleStart,
   input wire logic [1:0] cycleOwner,
   input wire logic [9:0] dramMuxAddr,
   input wire logic       dramDataBusOe,
   input wire logic       rowStrobe_n,
   input wire logic       lowByteColStrobe_n,
   input wire logic       highByteColStrobe_n,
   input wire logic       writeStrobe_n
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence colPulse;
      !highByteColStrobe_n [*3] ##1 highByteColStrobe_n;
   endsequence

   avalon_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest) else $error("register answer late");
   bus_in_access_a: assert property (dramDataBusOe |-> !rowStrobe_n)
      else $error("data bus driven outside an access");
   start_then_row_a: assert property (cycleStart |-> rowStrobe_n ##1 !rowStrobe_n)
      else $error("row strobe not one cycle after grant");
   row_addr_held_a: assert property ($fell(rowStrobe_n) |-> $stable(dramMuxAddr)
      && !dramMuxAddr[9]) else $error("row address moved at row strobe");
   row_before_col_a: assert property ($fell(highByteColStrobe_n) |->
      $past(rowStrobe_n) == 1'b0 && $past(rowStrobe_n, 2) == 1'b0)
      else $error("column strobe without row strobe");
   col_width_a: assert property ($fell(highByteColStrobe_n) |-> colPulse)
      else $error("column strobe width wrong");
   refresh_row_only_a: assert property (cycleOwner == `OWN_REFRESH |-> lowByteColStrobe_n
      && highByteColStrobe_n && writeStrobe_n) else $error("column strobe in refresh");
   display_ack_owner_a: assert property (displayAck |-> cycleOwner == `OWN_DISPLAY
      && rowStrobe_n) else $error("display ack outside display cycle");
   host_wait_bound_a: assert property ($fell(hostReady) |-> ##[1:60] hostReady)
      else $error("host wait too long");
   one_cycle_a: assert property (cycleStart |=> !cycleStart [*3])
      else $error("grants too close");
endmodule // display_dram_interface_assertions

bind display_dram_interface display_dram_interface_assertions chk_inst (
   .clk(clk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .hostReady(hostReady), .displayAck(displayAck),
   .cycleStart(cycleStart), .cycleOwner(cycleOwner), .dramMuxAddr(dramMuxAddr),
   .dramDataBusOe(dramDataBusOe), .rowStrobe_n(rowStrobe_n),
   .lowByteColStrobe_n(lowByteColStrobe_n), .highByteColStrobe_n(highByteColStrobe_n),
   .writeStrobe_n(writeStrobe_n));

/* File: verification/dram_chip_model.sv */
`timescale 1ns/10ps
module dram_chip_model (
   // Clock, straps and strobe arrangement
   input  wire logic        clk,
   input  wire logic        strapOn,
   input  wire logic [15:0] strapVal,
   input  wire logic        altMode,
   // DRAM pins
   input  wire logic [9:0]  dramMuxAddr,
   input  wire logic [15:0] dramDataBusOut,
   input  wire logic        dramDataBusOe,
   input  wire logic        rowStrobe_n,
   input  wire logic        lowByteColStrobe_n,
   input  wire logic        highByteColStrobe_n,
   input  wire logic        writeStrobe_n,
   output wire logic [15:0] dramDataBusIn
);
   logic [15:0] mem [0:262143];
   logic [8:0]  rowQ = 9'h0;
   logic [15:0] lastQ = 16'h0;
   wire         colOn;
   wire         wrLo;
   wire         wrHi;
   wire  [17:0] idx;
   assign colOn = altMode ? !highByteColStrobe_n : !(lowByteColStrobe_n && highByteColStrobe_n);
   assign wrLo = colOn && (altMode ? !lowByteColStrobe_n : !writeStrobe_n && !lowByteColStrobe_n);
   assign wrHi = colOn && (altMode ? !writeStrobe_n : !writeStrobe_n && !highByteColStrobe_n);
   assign idx = {rowQ, dramMuxAddr[8:0]};
   // A released bus shows the inverse of its last level, so stale data cannot pass.
   assign dramDataBusIn = dramDataBusOe ? dramDataBusOut : strapOn ? strapVal :
                          (colOn && !wrLo && !wrHi) ? mem[idx] : ~lastQ;
   always @(negedge rowStrobe_n) rowQ <= dramMuxAddr[8:0];
   always @(posedge clk) begin
      lastQ <= dramDataBusIn;
      if (!rowStrobe_n && wrLo) mem[idx][7:0] <= dramDataBusOut[7:0];
      if (!rowStrobe_n && wrHi) mem[idx][15:8] <= dramDataBusOut[15:8];
   end
endmodule // dram_chip_model

/* File: verification/display_dram_interface_tb.sv */
`timescale 1ns/10ps
`include "display_dram_consts.vh"
module display_dram_interface_tb;
   // Bench state
   logic        clk = 1'b0;
   integer      n_mismatch = 0;
   integer      checks = 0;
   integer      cycles = 0;
   logic [1:0]  ackOrder = 2'h0;
   logic [31:0] r;
   logic [15:0] q;
   logic        hit;
   logic        strapOn = 1'b1;
   logic [15:0] strapVal = 16'h2b5a;
   logic        altMode = 1'b0;
   // Design inputs
   logic        reset_n = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [19:0] hostAddr = 20'h0;
   logic        hostMemRead_n = 1'b1;
   logic        hostMemWrite_n = 1'b1;
   logic        hostByteHigh_n = 1'b1;
   logic        hostMemEnable = 1'b1;
   logic [15:0] hostDataIn = 16'h0;
   logic        displayReq = 1'b0;
   logic [17:0] displayAddr = 18'h0;
   logic        refreshReq = 1'b0;
   logic [8:0]  refreshRow = 9'h0;
   // Design outputs
   logic [31:0] avs_readdata;
   logic        avs_waitrequest, hostDataOe, hostReady, displayAck, refreshAck, cycleStart;
   logic [15:0] hostDataOut, displayData, dramDataBusIn, dramDataBusOut;
   logic [1:0]  cycleOwner;
   logic [9:0]  dramMuxAddr;
   logic        dramDataBusOe, rowStrobe_n, lowByteColStrobe_n, highByteColStrobe_n, writeStrobe_n;

   display_dram_interface display_dram_interface_inst (
      .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hostAddr(hostAddr),
      .hostMemRead_n(hostMemRead_n), .hostMemWrite_n(hostMemWrite_n),
      .hostByteHigh_n(hostByteHigh_n), .hostMemEnable(hostMemEnable), .hostDataIn(hostDataIn),
      .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .hostReady(hostReady),
      .displayReq(displayReq), .displayAddr(displayAddr), .refreshReq(refreshReq),
      .refreshRow(refreshRow), .displayAck(displayAck), .displayData(displayData),
      .refreshAck(refreshAck), .cycleStart(cycleStart), .cycleOwner(cycleOwner),
      .dramMuxAddr(dramMuxAddr), .dramDataBusIn(dramDataBusIn),
      .dramDataBusOut(dramDataBusOut), .dramDataBusOe(dramDataBusOe),
      .rowStrobe_n(rowStrobe_n), .lowByteColStrobe_n(lowByteColStrobe_n),
      .highByteColStrobe_n(highByteColStrobe_n), .writeStrobe_n(writeStrobe_n));

   dram_chip_model dram_chip_model_inst (
      .clk(clk), .strapOn(strapOn), .strapVal(strapVal), .altMode(altMode),
      .dramMuxAddr(dramMuxAddr), .dramDataBusOut(dramDataBusOut),
      .dramDataBusOe(dramDataBusOe), .rowStrobe_n(rowStrobe_n),
      .lowByteColStrobe_n(lowByteColStrobe_n), .highByteColStrobe_n(highByteColStrobe_n),
      .writeStrobe_n(writeStrobe_n), .dramDataBusIn(dramDataBusIn));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic give_verdict;
      if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   // Refresh requests drop on their acknowledge; the order of acknowledges is kept.
   always @(posedge clk) begin
      if (refreshAck === 1'b1) begin
         refreshReq <= 1'b0;
         ackOrder <= {ackOrder[0], 1'b1};
      end
      if (displayAck === 1'b1) ackOrder <= {ackOrder[0], 1'b0};
   end

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t register got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t data got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] strapExp(input logic [15:0] s);
      return {17'h0, s[14:13], s[8:4], s[12:9], s[3:0]};
   endfunction

   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic host(input logic wr, input logic [19:0] a, input logic hbN,
                       input logic [15:0] d, output logic [15:0] rd, output logic taken);
      integer n;
      n = 0;
      hostAddr <= a;
      hostByteHigh_n <= hbN;
      hostDataIn <= d;
      hostMemWrite_n <= !wr;
      hostMemRead_n <= wr;
      while (hostReady !== 1'b0 && n < 8) begin
         @(posedge clk);
         n++;
      end
      taken = (n < 8);
      while (hostReady !== 1'b1 && n < 80) begin
         @(posedge clk);
         n++;
      end
      rd = (hostDataOe === 1'b1) ? hostDataOut : 16'hxxxx;
      hostMemWrite_n <= 1'b1;
      hostMemRead_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask

   task automatic fetch(input logic [17:0] a, output logic [15:0] rd);
      integer n;
      n = 0;
      displayAddr <= a;
      displayReq <= 1'b1;
      while (displayAck !== 1'b1 && n < 80) begin
         @(posedge clk);
         n++;
      end
      rd = displayData;
      displayReq <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   task automatic doReset(input logic [15:0] s);
      strapVal <= s;
      strapOn <= 1'b1;
      reset_n <= 1'b0;
      repeat (12) @(posedge clk);
      chk_reg({dramDataBusOe, hostDataOe, rowStrobe_n, lowByteColStrobe_n,
               highByteColStrobe_n, writeStrobe_n}, 32'hf);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      strapOn <= 1'b0;
   endtask

   initial begin
      doReset(16'h2b5a);
      av(0, `REG_CTRL, 0, r);
      chk_reg(r, 32'h17);
      av(0, `REG_STATUS, 0, r);
      chk_reg(r & 32'h23f, 32'h201);
      av(1, `REG_STRAP, 32'hffff, r);
      av(0, `REG_STRAP, 0, r);
      chk_reg(r, strapExp(16'h2b5a));
      av(0, 4'hc, 0, r);
      chk_reg(r, 32'h0);
      av(0, 4'h1, 0, r);
      chk_reg(r, 32'h0);
      host(1, {3'h5, 16'h0123, 1'b0}, 0, 16'ha55a, q, hit);
      chk_reg(hit, 32'h0);
      av(1, `REG_CTRL, 32'h16, r);
      host(1, {3'h5, 16'h0123, 1'b0}, 0, 16'ha55a, q, hit);
      chk_reg(hit, 32'h1);
      fetch(18'h00123, q);
      chk_data(q, 16'ha55a);
      host(0, {3'h5, 16'h0123, 1'b0}, 1, 16'h0, q, hit);
      chk_data(q, 16'ha55a);
      host(1, {3'h5, 16'h0123, 1'b1}, 0, 16'h3c00, q, hit);
      host(1, {3'h4, 16'h0123, 1'b0}, 0, 16'hffff, q, hit);
      chk_reg(hit, 32'h0);
      hostMemEnable <= 1'b0;
      host(1, {3'h5, 16'h0123, 1'b0}, 0, 16'hffff, q, hit);
      chk_reg(hit, 32'h0);
      hostMemEnable <= 1'b1;
      fetch(18'h00123, q);
      chk_data(q, 16'h3c5a);
      av(1, `REG_CTRL, 32'h56, r);
      host(1, {3'h5, 16'h0123, 1'b0}, 0, 16'h7e81, q, hit);
      refreshRow <= 9'h1a5;
      refreshReq <= 1'b1;
      fetch(18'h20123, q);
      chk_data(q, 16'h7e81);
      chk_reg(ackOrder, 32'h2);
      refreshReq <= 1'b1;
      repeat (20) @(posedge clk);
      av(0, `REG_STATUS, 0, r);
      chk_reg(r[7:6], `OWN_REFRESH);
      altMode <= 1'b1;
      doReset(16'h4c93);
      av(0, `REG_STRAP, 0, r);
      chk_reg(r, strapExp(16'h4c93));
      av(1, `REG_CTRL, 32'h16, r);
      host(1, {3'h5, 16'h0077, 1'b0}, 0, 16'hbeef, q, hit);
      host(1, {3'h5, 16'h0077, 1'b0}, 1, 16'h1122, q, hit);
      host(1, {3'h5, 16'h0077, 1'b1}, 0, 16'h3300, q, hit);
      host(0, {3'h5, 16'h0077, 1'b0}, 0, 16'h0, q, hit);
      chk_data(q, 16'h3322);
      give_verdict();
   end
endmodule // display_dram_interface_tb
